// [design/tcef_channel.v]
`timescale 1ns/10ps
`default_nettype none
`include "tcef_regs.vh"

module tcef_channel #(
  parameter DMA_CLEAR = 1
) (
  // Clock, reset and standby
  input wire clock,
  input wire rst,
  input wire standby,
  // Register access for this channel
  input wire rd_flags,
  input wire wr_flags,
  input wire wr_enables,
  input wire [`TCEF_LOW_W-1:0] wdata,
  // Events, already qualified by mode
  input wire wrap_set,
  input wire b_set,
  input wire a_set,
  input wire dma_start_a,
  // State and requests
  output reg [`TCEF_LOW_W-1:0] flags,
  output reg [`TCEF_LOW_W-1:0] enables,
  output reg [`TCEF_LOW_W-1:0] irq
);

  reg [`TCEF_LOW_W-1:0] armed;
  reg [`TCEF_LOW_W-1:0] next_flags;
  reg [`TCEF_LOW_W-1:0] next_enables;
  reg [`TCEF_LOW_W-1:0] next_armed;
  reg [`TCEF_LOW_W-1:0] set_vec;
  reg [`TCEF_LOW_W-1:0] clr_vec;

  always @* begin
    set_vec = `TCEF_LOW_ZERO;
    set_vec[`TCEF_BIT_WRAP] = wrap_set;
    set_vec[`TCEF_BIT_B] = b_set;
    set_vec[`TCEF_BIT_A] = a_set;
    clr_vec = `TCEF_LOW_ZERO;
    if (wr_flags) begin
      // Only armed bits written with 0 clear; a 1 changes nothing
      clr_vec = armed & ~wdata;
    end
    if (DMA_CLEAR != 0 && dma_start_a) begin
      clr_vec[`TCEF_BIT_A] = 1'b1;
    end
    next_flags = (flags & ~clr_vec) | set_vec;
    if (wr_flags) begin
      next_armed = `TCEF_LOW_ZERO;
    end else if (rd_flags) begin
      // Arm drops at once if the flag is cleared in the read cycle
      next_armed = (armed | flags) & next_flags;
    end else begin
      next_armed = armed & next_flags;
    end
    next_enables = wr_enables ? wdata : enables;
    if (standby) begin
      next_flags = `TCEF_LOW_ZERO;
      next_enables = `TCEF_LOW_ZERO;
      next_armed = `TCEF_LOW_ZERO;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flags <= `TCEF_LOW_ZERO;
      enables <= `TCEF_LOW_ZERO;
      armed <= `TCEF_LOW_ZERO;
      irq <= `TCEF_LOW_ZERO;
    end else begin
      flags <= next_flags;
      enables <= next_enables;
      armed <= next_armed;
      // Registered from next values, so irq always equals flags & enables
      irq <= next_flags & next_enables;
    end
  end

endmodule // tcef_channel
`default_nettype wire

// [design/tcef_regs.vh]
`ifndef TCEF_REGS_VH
`define TCEF_REGS_VH

// Channel count and channels that take the DMA clear of the A flag
`define TCEF_NUM_CH 5
`define TCEF_DMA_CH 4
`define TCEF_CH_W 3

// Register select on the CPU port
`define TCEF_SEL_FLAGS 1'h0
`define TCEF_SEL_ENABLES 1'h1

// Register layout
`define TCEF_REG_RESET 8'hf8
`define TCEF_FIXED_ONES 5'h1f
`define TCEF_LOW_W 3
`define TCEF_LOW_ZERO 3'h0
`define TCEF_BIT_WRAP 2
`define TCEF_BIT_B 1
`define TCEF_BIT_A 0

// Read data for a channel number that does not exist
`define TCEF_UNMAPPED_READ 8'hff

// Channels whose counters may count down
`define TCEF_CH_PHASE 2
`define TCEF_CH_PAIR_LO 3
`define TCEF_CH_PAIR_HI 4

`endif

// [design/tcef_top.v]
// What this block does
// - Five channels, each with own flag and enable registers and requests.
// - Reset or standby forces each flag register to F8.
// - Bits 7..3 of both registers read as 1, ignore writes.
// - Wrap flag sets when counter rolls up from FFFF to 0000.
// - Wrap flag also sets when counter counts down from 0000 to FFFF.
// - Down wrap only on channel 2 two-phase, or channels 3/4 paired mode.
// - Software clears a flag only after a read showing 1, then a write of 0.
// - Writing 1 to a flag leaves it unchanged; software cannot set.
// - B flag sets on counter equal to register B in compare mode.
// - B flag sets on capture into register B in capture mode.
// - A flag sets on counter equal to register A in compare mode.
// - A flag sets on capture into register A in capture mode.
// - Channels 0..3 clear the A flag when its DMA transfer starts.
// - Reset or standby forces each enable register to F8.
// - Enable bit 2 gates the wrap request.
// - Enable bit 1 gates the B event request.
// - Enable bit 0 gates the A event request.
// - I/O control selects compare or capture source per general register.
`timescale 1ns/10ps
`default_nettype none
`include "tcef_regs.vh"

module tcef_top #(
  parameter NUM_CH = `TCEF_NUM_CH,
  parameter DMA_CH = `TCEF_DMA_CH
) (
  // Clock, reset and standby
  input wire clock,
  input wire rst,
  input wire standby,
  // CPU register port
  input wire [`TCEF_CH_W-1:0] bus_ch,
  input wire bus_reg,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  // Counter events per channel
  input wire [NUM_CH-1:0] count_up_wrap,
  input wire [NUM_CH-1:0] count_down_wrap,
  input wire [NUM_CH-1:0] match_a,
  input wire [NUM_CH-1:0] capture_a,
  input wire [NUM_CH-1:0] match_b,
  input wire [NUM_CH-1:0] capture_b,
  // Mode selections
  input wire [NUM_CH-1:0] io_a_capture,
  input wire [NUM_CH-1:0] io_b_capture,
  input wire two_phase_count_mode,
  input wire paired_mode_hi,
  input wire paired_mode_lo,
  // DMA start by the A event request
  input wire [NUM_CH-1:0] dma_start_a,
  // Interrupt requests
  output wire [NUM_CH-1:0] wrap_irq,
  output wire [NUM_CH-1:0] b_event_irq,
  output wire [NUM_CH-1:0] a_event_irq
);

  wire [NUM_CH*`TCEF_LOW_W-1:0] all_flags;
  wire [NUM_CH*`TCEF_LOW_W-1:0] all_enables;
  wire [NUM_CH*`TCEF_LOW_W-1:0] all_irq;
  reg [7:0] next_rdata;
  wire ch_ok;

  // Down counting allowed only in these channel and mode pairings
  function down_ok;
    input integer ch;
    input phase;
    input hi;
    input lo;
    begin
      down_ok = ((ch == `TCEF_CH_PHASE) && phase) ||
        ((ch == `TCEF_CH_PAIR_LO || ch == `TCEF_CH_PAIR_HI) && hi && !lo);
    end
  endfunction

  assign ch_ok = (bus_ch < NUM_CH);

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
      wire sel;
      wire wrap_set;
      wire a_set;
      wire b_set;
      assign sel = ch_ok && (bus_ch == i);
      assign wrap_set = count_up_wrap[i] || (count_down_wrap[i] &&
        down_ok(i, two_phase_count_mode, paired_mode_hi,
        paired_mode_lo));
      assign a_set = io_a_capture[i] ? capture_a[i] : match_a[i];
      assign b_set = io_b_capture[i] ? capture_b[i] : match_b[i];
      tcef_channel #(
        .DMA_CLEAR((i < DMA_CH) ? 1 : 0)
      ) u_ch (
        .clock(clock),
        .rst(rst),
        .standby(standby),
        .rd_flags(sel && bus_rd && (bus_reg == `TCEF_SEL_FLAGS)),
        .wr_flags(sel && bus_wr && (bus_reg == `TCEF_SEL_FLAGS)),
        .wr_enables(sel && bus_wr && (bus_reg == `TCEF_SEL_ENABLES)),
        .wdata(bus_wdata[`TCEF_LOW_W-1:0]),
        .wrap_set(wrap_set),
        .b_set(b_set),
        .a_set(a_set),
        .dma_start_a(dma_start_a[i]),
        .flags(all_flags[i*`TCEF_LOW_W +: `TCEF_LOW_W]),
        .enables(all_enables[i*`TCEF_LOW_W +: `TCEF_LOW_W]),
        .irq(all_irq[i*`TCEF_LOW_W +: `TCEF_LOW_W])
      );
      assign wrap_irq[i] = all_irq[i*`TCEF_LOW_W + `TCEF_BIT_WRAP];
      assign b_event_irq[i] = all_irq[i*`TCEF_LOW_W + `TCEF_BIT_B];
      assign a_event_irq[i] = all_irq[i*`TCEF_LOW_W + `TCEF_BIT_A];
    end
  endgenerate

  // Read data, upper bits fixed at one
  always @* begin
    next_rdata = bus_rdata;
    if (bus_rd) begin
      if (!ch_ok) begin
        next_rdata = `TCEF_UNMAPPED_READ;
      end else if (bus_reg == `TCEF_SEL_FLAGS) begin
        next_rdata = {`TCEF_FIXED_ONES,
          all_flags[bus_ch*`TCEF_LOW_W +: `TCEF_LOW_W]};
      end else begin
        next_rdata = {`TCEF_FIXED_ONES,
          all_enables[bus_ch*`TCEF_LOW_W +: `TCEF_LOW_W]};
      end
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= `TCEF_REG_RESET;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

endmodule // tcef_top
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'h0, rst = 1'h1, standby = 1'h0, rd_s = 1'h0, wr_s = 1'h0;
  logic rg = 1'h0, tp = 1'h0, ph = 1'h0, pl = 1'h0;
  logic [2:0] ch = 3'h0;
  logic [7:0] wd = 8'h00;
  logic [4:0] ioa = 5'h00, iob = 5'h00, go = 5'h00;
  logic [4:0] e [6] = '{default: 5'h00};
  wire logic [7:0] rdata;
  wire logic [4:0] dma, wi, bi, ai;
  int errors = 0, checks = 0, cyc = 0;
  tcef_top i_dut (.clock(clock), .rst(rst), .standby(standby), .bus_ch(ch),
    .bus_reg(rg), .bus_rd(rd_s), .bus_wr(wr_s), .bus_wdata(wd),
    .bus_rdata(rdata), .count_up_wrap(e[0]), .count_down_wrap(e[1]),
    .match_a(e[2]), .capture_a(e[3]), .match_b(e[4]), .capture_b(e[5]),
    .io_a_capture(ioa), .io_b_capture(iob), .two_phase_count_mode(tp),
    .paired_mode_hi(ph), .paired_mode_lo(pl), .dma_start_a(dma),
    .wrap_irq(wi), .b_event_irq(bi), .a_event_irq(ai));
  tcef_dma_model i_dma (.clock(clock), .rst(rst), .slow(1'h1), .req(ai),
    .go(go), .start(dma));
  initial forever #5 clock = ~clock;
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [7:0] s, input logic [7:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [2:0] c, input logic r, input logic [7:0] d);
    ch = c;
    rg = r;
    wd = d;
    wr_s = 1'h1;
    step;
    wr_s = 1'h0;
  endtask
  task automatic rd(input logic [2:0] c, input logic r, input logic [7:0] x);
    ch = c;
    rg = r;
    rd_s = 1'h1;
    step;
    rd_s = 1'h0;
    check(rdata, x);
  endtask
  task automatic pulse(input int k, input int c);
    e[k][c] = 1'h1;
    step;
    e[k][c] = 1'h0;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 1'h0;
    for (int c = 0; c < 6; c++) begin
      rd(c, 0, c < 5 ? 8'hf8 : 8'hff);
      rd(c, 1, c < 5 ? 8'hf8 : 8'hff);
    end
    for (int c = 0; c < 5; c++) begin
      wr(c, 1, 8'h07);
      rd(c, 1, 8'hff);
      ioa[c] = c[0];
      iob[c] = c[0];
      wr(c, 0, 8'hff);
      pulse(c[0] ? 2 : 3, c);
      pulse(c[0] ? 4 : 5, c);
      pulse(1, c);
      rd(c, 0, 8'hf8);
      pulse(c[0] ? 3 : 2, c);
      pulse(c[0] ? 5 : 4, c);
      pulse(0, c);
      wr(c, 0, 8'h00);
      rd(c, 0, 8'hff);
      check({5'h00, wi[c], bi[c], ai[c]}, 8'h07);
      wr(c, 0, 8'hf9);
      rd(c, 0, 8'hf9);
    end
    go = 5'h1f;
    repeat (4) step;
    check({3'h0, ai}, 8'h10);
    go = 5'h00;
    pulse(2, 0);
    rd(0, 0, 8'hf9);
    e[2][0] = 1'h1;
    wr(0, 0, 8'h00);
    e[2][0] = 1'h0;
    rd(0, 0, 8'hf9);
    wr(0, 0, 8'h00);
    rd(0, 0, 8'hf8);
    check({7'h0, ai[0]}, 8'h00);
    tp = 1'h1;
    ph = 1'h1;
    for (int c = 0; c < 5; c++) begin
      pulse(1, c);
      rd(c, 0, c < 2 ? 8'hf8 : (c == 4 ? 8'hfd : 8'hfc));
    end
    wr(3, 0, 8'h00);
    pl = 1'h1;
    pulse(1, 3);
    rd(3, 0, 8'hf8);
    wr(2, 1, 8'h00);
    check({7'h0, wi[2]}, 8'h00);
    standby = 1'h1;
    step;
    standby = 1'h0;
    rd(4, 0, 8'hf8);
    rd(4, 1, 8'hf8);
    check({3'h0, ai | wi}, 8'h00);
    wr(1, 1, 8'h07);
    pulse(0, 1);
    check({7'h0, wi[1]}, 8'h01);
    rst = 1'h1;
    step;
    rst = 1'h0;
    rd(1, 0, 8'hf8);
    rd(1, 1, 8'hf8);
    check({3'h0, wi}, 8'h00);
    report_and_stop;
  end
endmodule // tb_top
bind tcef_top tcef_props #(.NUM_CH(NUM_CH)) i_props (.clock(clock),
  .rst(rst), .standby(standby), .bus_ch(bus_ch), .bus_reg(bus_reg),
  .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .count_up_wrap(count_up_wrap),
  .match_a(match_a), .capture_a(capture_a), .io_a_capture(io_a_capture),
  .dma_start_a(dma_start_a), .wrap_irq(wrap_irq),
  .b_event_irq(b_event_irq), .a_event_irq(a_event_irq));
`default_nettype wire

// [verif/tcef_dma_model.sv]
`timescale 1ns/10ps
`default_nettype none
module tcef_dma_model (
  // Clock, reset, pacing
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  // Requests in, transfer starts out
  input wire logic [4:0] req,
  input wire logic [4:0] go,
  output logic [4:0] start
);
  logic [4:0] held;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      held <= 5'h00;
      start <= 5'h00;
    end else begin
      held <= go & req;
      start <= (slow ? held : go) & req & ~start;
    end
  end
endmodule // tcef_dma_model
`default_nettype wire

// [verif/tcef_props.sv]
`timescale 1ns/10ps
`default_nettype none
module tcef_props #(parameter NUM_CH = 5) (
  // Clock and control
  input wire logic clock, rst, standby,
  // Register port
  input wire logic [2:0] bus_ch,
  input wire logic bus_reg, bus_rd, bus_wr,
  input wire logic [7:0] bus_wdata, bus_rdata,
  // Events and requests
  input wire logic [NUM_CH-1:0] count_up_wrap, match_a, capture_a,
  input wire logic [NUM_CH-1:0] io_a_capture, dma_start_a,
  input wire logic [NUM_CH-1:0] wrap_irq, b_event_irq, a_event_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_fixed_ones: assert property (
    bus_rd && bus_ch < 3'h5 |=> bus_rdata[7:3] == 5'h1f)
    else $error("high bits not ones");
  a_standby_clear: assert property (
    standby |=> (wrap_irq | b_event_irq | a_event_irq) == '0)
    else $error("request after standby");
  a_a_cause: assert property (
    $rose(a_event_irq[0]) |-> $past(match_a[0] && !io_a_capture[0]
    || capture_a[0] && io_a_capture[0] || bus_wr && bus_reg && bus_ch == 0))
    else $error("A request without cause");
  a_wrap_cause: assert property (
    $rose(wrap_irq[0]) |-> $past(count_up_wrap[0]
    || bus_wr && bus_reg && bus_ch == 3'h0))
    else $error("wrap request without cause");
  a_enable_gate: assert property (
    bus_wr && bus_reg && bus_ch == 3'h2 && !bus_wdata[2] |=> !wrap_irq[2])
    else $error("wrap request not gated");
  a_dma_clear: assert property (
    dma_start_a[0] && !match_a[0] && !capture_a[0] |=> !a_event_irq[0])
    else $error("DMA did not clear A");
  a_dma_ch_four: assert property (
    dma_start_a[4] && a_event_irq[4] && !standby
    && !(bus_wr && bus_ch == 3'h4) |=> a_event_irq[4])
    else $error("DMA cleared channel four");
  a_flag_holds: assert property (
    a_event_irq[0] && !bus_wr && !standby && !dma_start_a[0]
    |=> a_event_irq[0])
    else $error("A flag cleared without write");
endmodule // tcef_props
`default_nettype wire
